/* hw/feature_configuration.sv */
/*
 * Feature configuration register with its serial access port and the
 * appended status bits that follow a conversion result.
 * Assumes the frame line, link clock and serial input come from a host with
 * clock polarity and phase zero, sampled here on CLK at well over twice SCK.
 */
`timescale 1ns/10ps
`include "cfgreg_params.svh"
module feature_configuration
    import cfgreg_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CONVERT_FRAME_LINE,
    input wire logic SCK,
    input wire logic SDI,
    input wire logic OV_EVENT,
    input wire logic RESULT_VALID,
    input wire logic [17:0] RESULT,
    output logic SDO,
    output logic SDO_OE,
    output logic STATUS_EN,
    output logic SPAN_EN,
    output logic HIZ_EN,
    output logic TURBO_EN
);
    logic cnv_s, sck_s, sdi_s, ov_s;
    logic sck_prev_q, cnv_prev_q;
    logic [7:0] cfg_q;
    logic ov_flag_q;
    logic [4:0] bit_cnt_q;
    logic [7:0] shin_q;
    access_t acc_q;
    logic [23:0] shout_q;
    logic [4:0] out_left_q;
    logic sdo_q, oe_q;
    logic read_done_q;

    // Pins are asynchronous to CLK
    sync2 u_cnv (.clk(CLK), .reset(RESET), .rst_val(1'b1), .din(CONVERT_FRAME_LINE), .dout(cnv_s));
    sync2 u_sck (.clk(CLK), .reset(RESET), .rst_val(1'b0), .din(SCK), .dout(sck_s));
    sync2 u_sdi (.clk(CLK), .reset(RESET), .rst_val(1'b0), .din(SDI), .dout(sdi_s));
    sync2 u_ov (.clk(CLK), .reset(RESET), .rst_val(1'b0), .din(OV_EVENT), .dout(ov_s));

    // Edge detection on synchronised copies
    wire sck_rise = sck_s & ~sck_prev_q;
    wire sck_fall = ~sck_s & sck_prev_q;
    wire frame_open = ~cnv_s & cnv_prev_q;
    wire in_frame = ~cnv_s;

    // Register image; reserved bits read zero
    wire [7:0] cfg_view = {3'h0, cfg_q[4:1], ov_flag_q};
    wire [7:0] cmd_next = {shin_q[6:0], sdi_s};
    wire cmd_ok = (cmd_next[7] == 1'b0) && (cmd_next[5:0] == `CMD_TAIL);
    wire cmd_edge = sck_rise && in_frame && (bit_cnt_q == 5'd7);
    wire byte_edge = sck_rise && in_frame && (bit_cnt_q == `INSTR_BITS - 5'd1);
    wire write_now = byte_edge && (acc_q == ACC_WRITE);
    wire [5:0] status_word = {ov_flag_q, cfg_q[3:1], 2'b00};

    always_ff @(posedge CLK) begin
        if (RESET) begin
            sck_prev_q <= 1'b0;
            cnv_prev_q <= 1'b1;
        end else begin
            sck_prev_q <= sck_s;
            cnv_prev_q <= cnv_s;
        end
    end

    // Instruction decoder; bits clock in on SCK rising edges
    always_ff @(posedge CLK) begin
        if (RESET || !in_frame) begin
            bit_cnt_q <= 5'd0;
            shin_q <= 8'h00;
            acc_q <= ACC_IDLE;
        end else if (sck_rise) begin
            shin_q <= cmd_next;
            if (bit_cnt_q != `INSTR_BITS) begin
                bit_cnt_q <= bit_cnt_q + 5'd1;
            end
            if (bit_cnt_q == 5'd7) begin
                acc_q <= !cmd_ok ? ACC_IGNORE : (cmd_next[6] ? ACC_READ : ACC_WRITE);
            end else if (bit_cnt_q == `INSTR_BITS - 5'd1) begin
                acc_q <= ACC_IGNORE;
            end
        end
    end

    // Writable fields update only once the whole byte is in
    always_ff @(posedge CLK) begin
        if (RESET) begin
            cfg_q <= `CFG_RESET_VALUE;
        end else if (write_now) begin
            cfg_q <= (cfg_q & ~`CFG_WRITE_MASK) | (cmd_next & `CFG_WRITE_MASK);
        end
    end

    // Sticky flag: an event wins over the clear by a read
    always_ff @(posedge CLK) begin
        if (RESET) begin
            ov_flag_q <= 1'b1;
            read_done_q <= 1'b0;
        end else begin
            if (ov_s) begin
                ov_flag_q <= 1'b0;
            end else if (read_done_q) begin
                ov_flag_q <= 1'b1;
            end
            read_done_q <= byte_edge && (acc_q == ACC_READ);
        end
    end

    // Output shifter; loads on frame start, shifts on SCK falling edges.
    // A read loads the register image; otherwise result then status bits.
    always_ff @(posedge CLK) begin
        if (RESET || !in_frame) begin
            shout_q <= 24'h000000;
            out_left_q <= 5'd0;
            sdo_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (frame_open) begin
            shout_q <= {RESULT, status_word};
            out_left_q <= RESULT_VALID ? (cfg_q[4] ? 5'd24 : `RESULT_BITS) : 5'd0;
            sdo_q <= RESULT_VALID & RESULT[17];
            oe_q <= RESULT_VALID;
        end else if (cmd_edge && cmd_ok && cmd_next[6]) begin
            // The 8th fall still shifts; a spare lead bit keeps bit 7 for the 9th rise
            shout_q <= {1'b0, cfg_view, 15'h0000};
            out_left_q <= 5'd9;
            sdo_q <= cfg_view[7];
            oe_q <= 1'b1;
        end else if (sck_fall && out_left_q != 5'd0) begin
            shout_q <= {shout_q[22:0], 1'b0};
            out_left_q <= out_left_q - 5'd1;
            // Drops to zero with the enable so a finished line never shows stale data
            sdo_q <= shout_q[22] & (out_left_q != 5'd1);
            oe_q <= (out_left_q != 5'd1);
        end
    end

    assign SDO = sdo_q;
    assign SDO_OE = oe_q;
    assign STATUS_EN = cfg_q[4];
    assign SPAN_EN = cfg_q[3];
    assign HIZ_EN = cfg_q[2];
    assign TURBO_EN = cfg_q[1];

    // Checks; the read and result steps are named so several properties share them
    // A read command recognised on the 8th rising edge of a frame
    sequence read_cmd_s;
        cmd_edge && cmd_ok && cmd_next[6];
    endsequence
    // A write command recognised on the 8th rising edge of a frame
    sequence write_cmd_s;
        cmd_edge && cmd_ok && !cmd_next[6];
    endsequence
    // A frame opens with a conversion result ready to shift out
    sequence result_open_s;
        frame_open && RESULT_VALID;
    endsequence

    // Register fields: only a completed write may move them
    reserved_zero_a: assert property (@(posedge CLK) disable iff (RESET)
        read_cmd_s |=> shout_q[22:20] == 3'h0) else $error("reserved bits nonzero");
    write_apply_a: assert property (@(posedge CLK) disable iff (RESET)
        write_now |=> cfg_q[4:1] == $past(cmd_next[4:1])) else $error("write lost");
    status_follow_a: assert property (@(posedge CLK) disable iff (RESET)
        write_now |=> STATUS_EN == $past(cmd_next[4]))
        else $error("status enable mismatch");
    span_follow_a: assert property (@(posedge CLK) disable iff (RESET)
        !write_now |=> $stable(SPAN_EN)) else $error("span changed");
    hiz_follow_a: assert property (@(posedge CLK) disable iff (RESET)
        !write_now |=> $stable(HIZ_EN)) else $error("hiz changed");
    turbo_follow_a: assert property (@(posedge CLK) disable iff (RESET)
        !write_now |=> $stable(TURBO_EN)) else $error("turbo changed");

    // Overvoltage flag: a read clear that meets a live condition must not win
    ov_event_a: assert property (@(posedge CLK) disable iff (RESET)
        ov_s |=> !cfg_view[0]) else $error("event not flagged");
    ov_sticky_a: assert property (@(posedge CLK) disable iff (RESET)
        !cfg_view[0] && !read_done_q |=> !cfg_view[0]) else $error("flag lost");
    ov_clear_a: assert property (@(posedge CLK) disable iff (RESET)
        read_done_q && !ov_s |=> cfg_view[0]) else $error("flag not cleared");

    // Command decode, read image and byte-wise update
    bad_cmd_a: assert property (@(posedge CLK) disable iff (RESET)
        cmd_edge && !cmd_ok |=> acc_q == ACC_IGNORE) else $error("bad command taken");
    write_decode_a: assert property (@(posedge CLK) disable iff (RESET)
        write_cmd_s |=> acc_q == ACC_WRITE) else $error("write not decoded");
    read_decode_a: assert property (@(posedge CLK) disable iff (RESET)
        read_cmd_s |=> acc_q == ACC_READ) else $error("read not decoded");
    read_load_a: assert property (@(posedge CLK) disable iff (RESET)
        read_cmd_s |=> SDO_OE && SDO == $past(cfg_view[7]) && shout_q[22:15] == $past(cfg_view))
        else $error("read image not loaded");
    byte_only_a: assert property (@(posedge CLK) disable iff (RESET)
        $changed(cfg_q) |-> $past(write_now)) else $error("early update");

    // Result readout and frame end
    status_long_a: assert property (@(posedge CLK) disable iff (RESET)
        result_open_s ##0 STATUS_EN |=> out_left_q == 5'd24) else $error("status bits missing");
    status_short_a: assert property (@(posedge CLK) disable iff (RESET)
        result_open_s ##0 !STATUS_EN |=> out_left_q == `RESULT_BITS)
        else $error("status bits sent");
    status_bits_a: assert property (@(posedge CLK) disable iff (RESET)
        result_open_s |=> shout_q[5:0] == {$past(cfg_view[0]), $past(SPAN_EN), $past(HIZ_EN),
        $past(TURBO_EN), 2'b00}) else $error("status bits wrong");
    frame_close_a: assert property (@(posedge CLK) disable iff (RESET)
        !in_frame |=> !SDO_OE) else $error("output left on");
endmodule : feature_configuration

/* pkg/cfgreg_params.svh */
/*
 * Constants of the feature configuration register and its serial access command.
 * Assumes it is included by the one module that uses the package; defines only.
 */
`ifndef CFGREG_PARAMS_SVH
`define CFGREG_PARAMS_SVH

// Field positions
`define CFG_STATUS_EN_BIT 3'd4
`define CFG_SPAN_EN_BIT 3'd3
`define CFG_HIZ_EN_BIT 3'd2
`define CFG_TURBO_EN_BIT 3'd1
`define CFG_OV_BIT 3'd0
// Reset value of the whole register
`define CFG_RESET_VALUE 8'h01
// Mask of the writable fields
`define CFG_WRITE_MASK 8'h1e
// Low six bits of the access command
`define CMD_TAIL 6'h14
// Instruction length in link clock edges
`define INSTR_BITS 5'd16
// Conversion result width and status bit count
`define RESULT_BITS 5'd18
`define STATUS_BITS 3'd6

`endif

/* pkg/cfgreg_pkg.sv */
/*
 * Types shared by the configuration register block.
 * Assumes nothing of its surroundings.
 */
package cfgreg_pkg;
    typedef enum logic [1:0] {
        ACC_IDLE,
        ACC_WRITE,
        ACC_READ,
        ACC_IGNORE
    } access_t;
endpackage : cfgreg_pkg

/* hw/sync2.sv */
/*
 * Two flip-flop synchroniser for one level.
 * Assumes the input is asynchronous to CLK.
 */
`timescale 1ns/10ps
module sync2 (
    input wire logic clk,
    input wire logic reset,
    input wire logic rst_val,
    input wire logic din,
    output logic dout
);
    logic meta_q;

    // First stage is read only by the second
    always_ff @(posedge clk) begin
        if (reset) begin
            // Both stages start at the pin's idle level, so no false edge follows reset
            meta_q <= rst_val;
            dout <= rst_val;
        end else begin
            meta_q <= din;
            dout <= meta_q;
        end
    end
endmodule : sync2

/* dv/spi_host_model.sv */
/* Host model: frames 16-bit instructions, mode 0.
   Assumes CLK at 25 MHz; link clock 8 CLK a period, still between frames. */
`timescale 1ns/10ps
module spi_host_model (
    input wire logic clk,
    input wire logic sdo,
    output logic convert_frame_line,
    output logic sck,
    output logic sdi,
    output logic [23:0] rd_data,
    output logic rd_seen
);
    initial begin
        convert_frame_line = 1'b1;
        sck = 1'b0;
        sdi = 1'b1;
        rd_data = 24'h000000;
        rd_seen = 1'b0;
    end
    // SDI set at SCK fall, SDO taken as SCK rises; the design shifts at falls.
    // Sends the low n bits of word MSB first; SDO is shifted in from bit skip on.
    // Eight CLK a period is 3.125 MHz, above every 100 kSPS host clock minimum
    task automatic xfer(input logic [23:0] word, input int n, input int skip,
        input logic is_rd);
        @(posedge clk);
        convert_frame_line <= 1'b0;
        rd_data <= 24'h000000;
        for (int i = 0; i < n; i++) begin
            sdi <= word[n-1-i];
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            if (i >= skip) begin
                rd_data <= {rd_data[22:0], sdo};
            end
            repeat (4) @(posedge clk);
            sck <= 1'b0;
        end
        repeat (4) @(posedge clk);
        convert_frame_line <= 1'b1;
        sdi <= ~sdi; // Idle level flips so a stale bit is never relied on
        rd_seen <= is_rd;
        @(posedge clk);
        rd_seen <= 1'b0;
        repeat (8) @(posedge clk);
    endtask : xfer
endmodule : spi_host_model

/* dv/feature_configuration_tb.sv */
/* Bench for the configuration register over its serial port.
   Assumes the host model is the only source of frames; results only in readout. */
`timescale 1ns/10ps
module feature_configuration_tb;
    logic clk, reset, ov_event, convert_frame_line, sck, sdi, sdo, sdo_oe, rd_seen;
    logic status_en, span_en, hiz_en, turbo_en;
    logic [23:0] rd_data, full;
    logic [7:0] v, cur;
    logic [23:0] exp_q[$];
    logic [17:0] res_val;
    logic res_ok;
    int n;
    wire logic [7:0] en_img = {3'b000, status_en, span_en, hiz_en, turbo_en, 1'b0};
    int failures = 0;
    int num_checks = 0;
    feature_configuration feature_configuration_inst (.CLK(clk), .RESET(reset),
        .CONVERT_FRAME_LINE(convert_frame_line), .SCK(sck), .SDI(sdi), .OV_EVENT(ov_event), .RESULT_VALID(res_ok),
        .RESULT(res_val), .SDO(sdo), .SDO_OE(sdo_oe), .STATUS_EN(status_en),
        .SPAN_EN(span_en), .HIZ_EN(hiz_en), .TURBO_EN(turbo_en));
    spi_host_model spi_host_model_inst (.clk(clk), .sdo(sdo), .convert_frame_line(convert_frame_line), .sck(sck),
        .sdi(sdi), .rd_data(rd_data), .rd_seen(rd_seen));
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] d);
        spi_host_model_inst.xfer({16'h0014, d}, 16, 8, 1'b0);
    endtask : wr
    // The expected byte is noted first; the monitor compares it later
    task automatic rd(input logic [7:0] e);
        exp_q.push_back({16'h0000, e});
        spi_host_model_inst.xfer(24'h0054a5, 16, 8, 1'b1);
    endtask : rd
    task automatic wrap_up();
        $display("Checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : wrap_up
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // Read results are taken off the queue in the order they were noted
    always @(posedge clk) begin
        if (rd_seen === 1'b1) begin
            chk(rd_data, exp_q.pop_front());
        end
    end
    initial begin
        #1000000;
        failures++;
        wrap_up();
    end
    initial begin
        reset = 1'b1;
        ov_event = 1'b0;
        res_ok = 1'b0;
        res_val = 18'h00000;
        void'($urandom(32'h476fe68c));
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        rd(8'h01);
        chk({7'h00, sdo_oe}, 8'h00);
        $display("Test reset image done");
        // One-hot enables first, then random bytes; read-only bits set in every write
        for (int i = 0; i < 7; i++) begin
            v = (i < 4) ? (8'h02 << i) : 8'($urandom);
            wr(v | 8'he1);
            cur = (v & 8'h1e) | 8'h01;
            chk(en_img, cur & 8'h1e);
            rd(cur);
        end
        $display("Test write and read back done");
        spi_host_model_inst.xfer({8'h00, 8'hd4, ~cur}, 16, 8, 1'b0);
        spi_host_model_inst.xfer({8'h00, 8'h34, ~cur}, 16, 8, 1'b0);
        chk(en_img, cur & 8'h1e);
        rd(cur);
        $display("Test refused commands done");
        @(posedge clk);
        ov_event <= 1'b1;
        repeat (8) @(posedge clk);
        rd(cur & 8'hfe);
        rd(cur & 8'hfe);
        ov_event <= 1'b0;
        repeat (8) @(posedge clk);
        rd(cur & 8'hfe);
        rd(cur);
        $display("Test overvoltage flag done");
        // Result readout: whole with status, cut after two status bits, status off
        res_val <= 18'($urandom);
        res_ok <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            v = (k == 2) ? 8'h0a : 8'h1e;
            wr(v);
            n = (k == 1) ? 20 : 24;
            full = {res_val, (v[4] ? {1'b1, v[3:1], 2'b00} : 6'h00)};
            exp_q.push_back(24'(full >> (24 - n)));
            spi_host_model_inst.xfer(24'hffffff, n, 0, 1'b1);
        end
        res_ok <= 1'b0;
        $display("Test result readout done");
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        repeat (4) @(posedge clk);
        chk(en_img, 8'h00);
        rd(8'h01);
        $display("Test second reset done");
        repeat (4) @(posedge clk);
        chk(8'(exp_q.size()), 8'h00);
        wrap_up();
    end
endmodule : feature_configuration_tb
